// *** verilog/mhrs_defines.svh ***
`ifndef MHRS_DEFINES_SVH
`define MHRS_DEFINES_SVH
// Clock rate in kHz (25 MHz)
`define MHRS_CLK_KHZ 25000
// Least low time of the restart line, in ms
`define MHRS_RST_HOLD_MS 1000
// Least time from power request to operational, in ms
`define MHRS_ACTIVATE_MS 50000
// Power-off phase length, in ms (plain default)
`define MHRS_OFF_PHASE_MS 40
// Cycle counts derived from the times above
`define MHRS_RST_HOLD_CYC (`MHRS_RST_HOLD_MS * `MHRS_CLK_KHZ)
`define MHRS_ACTIVATE_CYC (`MHRS_ACTIVATE_MS * `MHRS_CLK_KHZ)
`define MHRS_OFF_PHASE_CYC (`MHRS_OFF_PHASE_MS * `MHRS_CLK_KHZ)
// Width of the shared timer
`define MHRS_CNT_W 32
`endif

// *** verilog/mhrs_pkg.sv ***
`default_nettype none
package mhrs_pkg;
  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    MHRS_OFF = 3'h0,
    MHRS_BOOT = 3'h1,
    MHRS_ON = 3'h3,
    MHRS_FINAL = 3'h2,
    MHRS_DOWN = 3'h6
  } mhrs_state_e;
endpackage : mhrs_pkg
`default_nettype wire

// *** verilog/mhrs_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels handed from the input stage to the sequencer
interface mhrs_sync_if;
  logic restart_n; // Restart line, low active
  logic power_en; // Power-enable request
  logic fast_pin; // Fast-off trigger pin
  modport src (output restart_n, power_en, fast_pin);
  modport dst (input restart_n, power_en, fast_pin);
endinterface : mhrs_sync_if
`default_nettype wire

// *** verilog/mhrs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module mhrs_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [2:0] pins_in,
  mhrs_sync_if.src sync
);
  // Two stages per pin; stage one feeds only stage two
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
  } mhrs_sync_s;
  mhrs_sync_s st_ff;
  mhrs_sync_s nxt_st;
  // Next state: shift the pins through
  always_comb begin
    nxt_st = st_ff;
    if (ce_in) begin
      nxt_st.meta = pins_in;
      nxt_st.stable = st_ff.meta;
    end
  end
  // Reset to idle levels: restart released, no power, trigger high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '{meta: 3'h5, stable: 3'h5};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign sync.restart_n = st_ff.stable[0];
  assign sync.power_en = st_ff.stable[1];
  assign sync.fast_pin = st_ff.stable[2];
endmodule : mhrs_sync
`default_nettype wire

// *** verilog/mhrs_top.sv ***
// Function
// - Hard restart only from the restart line
// - Indicator falls when power-off phase ends
// - Indicator rises when power-on phase ends
// - Indicator idle until explicitly enabled
// - One pin shows boot and shutdown
// - Fast-off with supply and enable present re-powers
// - Falling trigger edge starts fast-off
// - Operational no sooner than fifty seconds
`timescale 1ns/1ps
`default_nettype none
`include "mhrs_defines.svh"
module mhrs_top import mhrs_pkg::*; #(
  parameter int unsigned RST_HOLD_CYC = `MHRS_RST_HOLD_CYC,
  parameter int unsigned ACTIVATE_CYC = `MHRS_ACTIVATE_CYC,
  parameter int unsigned OFF_PHASE_CYC = `MHRS_OFF_PHASE_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic RESTART_N_IN,
  input wire logic POWER_EN_IN,
  input wire logic MAIN_SUPPLY_IN,
  input wire logic FAST_PIN_IN,
  input wire logic IND_ASSIGN_IN,
  input wire logic FAST_ASSIGN_IN,
  output logic IND_OUT,
  output logic IND_OE_OUT,
  output logic OPERATIONAL_OUT,
  output logic POWERED_OUT
);
  // Counts must be nonzero; refused while elaborating, not at run time
  if (RST_HOLD_CYC < 1 || ACTIVATE_CYC < 1 || OFF_PHASE_CYC < 1) begin : g_bad
    $error("mhrs_top: cycle counts must be at least one");
  end

  mhrs_sync_if sync_bus ();

  // Pin synchroniser; supply is held by the state below
  mhrs_sync u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .pins_in({FAST_PIN_IN, POWER_EN_IN, RESTART_N_IN}),
    .sync(sync_bus)
  );

  // Whole state of the sequencer
  typedef struct packed {
    mhrs_state_e state;
    logic [`MHRS_CNT_W-1:0] timer; // Phase timer
    logic [`MHRS_CNT_W-1:0] low_cnt; // Restart low time
    logic hold_met; // Restart held long enough
    logic hard; // Current shutdown is a hard restart
    logic ind_en; // Indicator assigned
    logic fast_en; // Fast-off trigger assigned
    logic fast_prev; // Last trigger level, for edges
    logic supply_m; // Supply synchroniser stage one
    logic supply_s; // Supply synchroniser stage two
    logic ind; // Indicator level
  } mhrs_s;
  mhrs_s st_ff;
  mhrs_s nxt_st;

  logic fast_fall;
  logic restart_rel;

  // Trigger falling edge, only once assigned
  assign fast_fall = st_ff.fast_en && st_ff.fast_prev && !sync_bus.fast_pin;
  // Release after a long enough low pulse
  assign restart_rel = st_ff.hold_met && sync_bus.restart_n;

  // Sequencer next-state logic
  always_comb begin
    nxt_st = st_ff;
    if (CE_IN) begin
      nxt_st.supply_m = MAIN_SUPPLY_IN;
      nxt_st.supply_s = st_ff.supply_m;
      nxt_st.fast_prev = sync_bus.fast_pin;
      // Assignment commands latch; nothing clears them but reset
      if (IND_ASSIGN_IN) begin
        nxt_st.ind_en = 1'b1;
      end
      if (FAST_ASSIGN_IN) begin
        nxt_st.fast_en = 1'b1;
      end
      // Measure the restart low time; saturate to avoid wrap
      if (!sync_bus.restart_n) begin
        if (st_ff.low_cnt < RST_HOLD_CYC[`MHRS_CNT_W-1:0]) begin
          nxt_st.low_cnt = st_ff.low_cnt + 1'b1;
        end else begin
          nxt_st.hold_met = 1'b1;
        end
      end else begin
        nxt_st.low_cnt = '0;
        nxt_st.hold_met = 1'b0;
      end
      if (st_ff.timer != '0) begin
        nxt_st.timer = st_ff.timer - 1'b1;
      end
      case (st_ff.state)
        MHRS_OFF: begin
          // Power on needs supply, enable, and restart released
          if (st_ff.supply_s && sync_bus.power_en && sync_bus.restart_n) begin
            nxt_st.state = MHRS_BOOT;
            nxt_st.timer = ACTIVATE_CYC[`MHRS_CNT_W-1:0] - 1'b1;
          end
        end
        MHRS_BOOT: begin
          if (restart_rel) begin
            nxt_st.state = MHRS_FINAL;
            nxt_st.hard = 1'b1;
            nxt_st.timer = OFF_PHASE_CYC[`MHRS_CNT_W-1:0] - 1'b1;
          end else if (!sync_bus.power_en) begin
            nxt_st.state = MHRS_OFF;
          end else if (st_ff.timer == '0) begin
            nxt_st.state = MHRS_ON;
            if (st_ff.ind_en) begin
              nxt_st.ind = 1'b1;
            end
          end
        end
        MHRS_ON: begin
          if (restart_rel || fast_fall || !sync_bus.power_en) begin
            nxt_st.state = MHRS_FINAL;
            nxt_st.hard = restart_rel;
            nxt_st.timer = OFF_PHASE_CYC[`MHRS_CNT_W-1:0] - 1'b1;
          end
        end
        MHRS_FINAL: begin
          // Finalisation done: shutdown shown by falling indicator
          if (st_ff.timer == '0) begin
            nxt_st.state = MHRS_DOWN;
            nxt_st.ind = 1'b0;
          end
        end
        MHRS_DOWN: begin
          // Back to OFF in every case; power returns there only with supply and enable
          if (st_ff.hard || (st_ff.supply_s && sync_bus.power_en)) begin
            nxt_st.state = MHRS_OFF;
            nxt_st.hard = 1'b0;
          end else if (!st_ff.supply_s || !sync_bus.power_en) begin
            nxt_st.state = MHRS_OFF;
          end
        end
        default: begin
          nxt_st.state = MHRS_OFF;
        end
      endcase
    end
  end

  // Register the whole state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_ff <= '{state: MHRS_OFF, timer: '0, low_cnt: '0, hold_met: 1'b0,
        hard: 1'b0, ind_en: 1'b0, fast_en: 1'b0, fast_prev: 1'b1,
        supply_m: 1'b0, supply_s: 1'b0, ind: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Indicator driven only once assigned; floats otherwise
  assign IND_OUT = st_ff.ind;
  assign IND_OE_OUT = st_ff.ind_en;
  assign OPERATIONAL_OUT = (st_ff.state == MHRS_ON);
  assign POWERED_OUT = (st_ff.state != MHRS_OFF) && (st_ff.state != MHRS_DOWN);
endmodule : mhrs_top
`default_nettype wire

// *** tb/mhrs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-level watcher for the restart sequencer
module mhrs_sva #(
  parameter int unsigned ACTIVATE_CYC = 50,
  parameter int unsigned OFF_PHASE_CYC = 10
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic IND_ASSIGN_IN,
  input wire logic POWER_EN_IN,
  input wire logic MAIN_SUPPLY_IN,
  input wire logic IND_OUT,
  input wire logic IND_OE_OUT,
  input wire logic OPERATIONAL_OUT,
  input wire logic POWERED_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic seen_ff; // Indicator assign seen
  logic [31:0] cnt_ff; // Powered but not operational
  // Phase length counter, cleared outside boot and final
  always_ff @(posedge CLK_IN) begin
    seen_ff <= !RST_IN && (seen_ff || IND_ASSIGN_IN);
    if (RST_IN || !POWERED_OUT || OPERATIONAL_OUT) cnt_ff <= 32'h0;
    else cnt_ff <= cnt_ff + 32'h1;
  end
  sequence s_on; $rose(OPERATIONAL_OUT); endsequence
  sequence s_down; $fell(IND_OUT); endsequence
  chk_reset_quiet: assert property (disable iff (1'b0)
    RST_IN |=> !(IND_OUT || IND_OE_OUT || POWERED_OUT))
    else $error("outputs not cleared by reset");
  chk_oe_assign: assert property (IND_OE_OUT |-> seen_ff)
    else $error("indicator driven before assign");
  chk_rise_enabled: assert property ($rose(IND_OUT) |->
    IND_OE_OUT && OPERATIONAL_OUT) else $error("bad indicator rise");
  chk_on_shows: assert property (s_on ##0 IND_OE_OUT |->
    ##[0:1] IND_OUT) else $error("boot done not shown");
  chk_fall_ends_off: assert property (s_down |->
    $fell(POWERED_OUT) && cnt_ff >= OFF_PHASE_CYC)
    else $error("bad indicator fall");
  chk_boot_length: assert property (s_on |->
    cnt_ff >= ACTIVATE_CYC) else $error("operational too early");
  chk_power_cause: assert property ($rose(POWERED_OUT) |->
    $past(POWER_EN_IN, 3) && $past(MAIN_SUPPLY_IN, 3))
    else $error("powered without request");
  chk_off_final: assert property ($fell(OPERATIONAL_OUT) |->
    POWERED_OUT) else $error("off phase skipped");
endmodule : mhrs_sva
`default_nettype wire

// *** tb/mhrs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host side: open-drain restart and power request
module mhrs_host (
  input wire logic clk_in,
  input wire logic pull_in,
  input wire logic en_in,
  input wire logic ind_in,
  output logic restart_n_out,
  output logic power_en_out,
  output logic ind_seen_out
);
  logic [1:0] ind_sync_ff; // Indicator synchroniser
  // Only pulls low, otherwise the line floats high
  assign restart_n_out = pull_in ? 1'b0 : 1'b1;
  // Power request follows the bench level
  assign power_en_out = en_in;
  // Two flops before the host acts on indicator edges
  always_ff @(posedge clk_in) begin
    ind_sync_ff <= {ind_sync_ff[0], ind_in};
  end
  assign ind_seen_out = ind_sync_ff[1];
endmodule : mhrs_host
`default_nettype wire

// *** tb/mhrs_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module mhrs_top_test;
  logic clk = 0, rst = 1, pull = 0, en = 0, sup = 0;
  logic fast = 1, ia = 0, fa = 0, ind, oe, op, pw, rn, pe;
  logic ce = 1, hs;
  int bad_count = 0, samples_checked = 0;
  wire logic [3:0] obs = {hs, ind, pw, op}; // Watched levels
  always #20 clk = ~clk;
  mhrs_host i_host (.clk_in(clk), .pull_in(pull), .en_in(en),
    .ind_in(ind), .restart_n_out(rn), .power_en_out(pe),
    .ind_seen_out(hs));
  mhrs_top #(.RST_HOLD_CYC(20), .ACTIVATE_CYC(50), .OFF_PHASE_CYC(10))
  i_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .RESTART_N_IN(rn),
    .POWER_EN_IN(pe), .MAIN_SUPPLY_IN(sup), .FAST_PIN_IN(fast),
    .IND_ASSIGN_IN(ia), .FAST_ASSIGN_IN(fa), .IND_OUT(ind),
    .IND_OE_OUT(oe), .OPERATIONAL_OUT(op), .POWERED_OUT(pw));
  task check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t level mismatch", $time);
    end
  endtask : check
  task conclude;
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // Bounded wait: 0 operational, 1 powered, 2 indicator, 3 host view
  task wait_lvl(input int k, input logic v);
    int i;
    for (i = 0; i < 200 && obs[k] !== v; i++) @(negedge clk);
    check(i < 200, 1'b1);
  endtask : wait_lvl
  // Boot without indicator: pin stays quiet, no early ready
  task t_boot;
    en = 1;
    sup = 1;
    idle(40);
    check(op, 1'b0);
    wait_lvl(0, 1'b1);
    check(oe, 1'b0);
  endtask : t_boot
  // Short pulse refused, long one restarts; indicator stays low through shutdown, rises at boot
  task t_restart;
    ia = 1;
    pull = 1;
    idle(10);
    pull = 0;
    idle(8);
    check(op, 1'b1);
    pull = 1;
    idle(30);
    pull = 0;
    wait_lvl(1, 1'b0);
    check(ind, 1'b0);
    check(oe, 1'b1);
    wait_lvl(0, 1'b1);
    check(ind, 1'b1);
  endtask : t_restart
  // Trigger ignored until assigned; fast-off then re-powers
  task t_fast;
    fast = 0;
    idle(8);
    fast = 1;
    idle(4);
    check(op, 1'b1);
    fa = 1;
    idle(4);
    fast = 0;
    wait_lvl(1, 1'b0);
    check(ind, 1'b0);
    wait_lvl(1, 1'b1);
    check(op, 1'b0);
    wait_lvl(0, 1'b1);
  endtask : t_fast
  // Host acts on the shutdown indication and drops power for good
  task t_quiet;
    fast = 1;
    idle(4);
    fast = 0;
    wait_lvl(3, 1'b0);
    en = 0;
    sup = 0;
    idle(60);
    check(pw, 1'b0);
    check(ind, 1'b0);
  endtask : t_quiet
  // Mid-run reset drops the assignment; low enable freezes all
  task t_reset;
    ia = 0;
    fa = 0;
    rst = 1;
    idle(2);
    rst = 0;
    idle(2);
    check(oe, 1'b0);
    ce = 0;
    en = 1;
    sup = 1;
    idle(20);
    check(pw, 1'b0);
    ce = 1;
    wait_lvl(1, 1'b1);
  endtask : t_reset
  initial begin
    idle(16);
    rst = 0;
    t_boot;
    t_restart;
    t_fast;
    t_quiet;
    t_reset;
    conclude;
  end
  // Watchdog far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    conclude;
  end
endmodule : mhrs_top_test
bind mhrs_top mhrs_sva #(.ACTIVATE_CYC(ACTIVATE_CYC),
  .OFF_PHASE_CYC(OFF_PHASE_CYC)) i_sva (.*);
`default_nettype wire
